// ===== src/idr_map.svh
// Constants for the identification readout link
`ifndef IDR_MAP_SVH
`define IDR_MAP_SVH
`define IDR_RSV_WR      8'hF8
`define IDR_RSV_RD      8'hF9
`define IDR_TYPE_CODE   4'hA
`define IDR_ID_BYTES    2'h3
`define IDR_SCL_HALF    16'h0010
`define IDR_RECOV_CLKS  4'h9
`endif

// ===== src/idr_pkg.sv
// State types for the two ends of the identification link, one type per end
package idr_pkg;
    typedef enum logic [2:0] {
        IDR_T_IDLE, IDR_T_RSV, IDR_T_DEV, IDR_T_WAITRS, IDR_T_RD, IDR_T_SEND, IDR_T_MACK
    } idr_tstate_t;
    typedef enum logic [3:0] {
        IDR_C_IDLE, IDR_C_RECOV, IDR_C_START, IDR_C_TXBIT, IDR_C_TXACK, IDR_C_RXBIT,
        IDR_C_RXACK, IDR_C_STOP, IDR_C_RSTART, IDR_C_DONE
    } idr_cstate_t;
endpackage

// ===== src/idr_link_if.sv
// Open-drain two-wire link joining controller and target
`timescale 1ns/1ps
`default_nettype none
interface idr_link_if;
    logic sclOe;
    logic sdaOeCtl;
    logic sdaOeTgt;
    logic scl;
    logic sda;
    // Open drain: any enable pulls low
    assign scl = ~sclOe;
    assign sda = ~(sdaOeCtl | sdaOeTgt);
    modport ctl (output sclOe, output sdaOeCtl, input scl, input sda);
    modport tgt (output sdaOeTgt, input scl, input sda);
endinterface
`default_nettype wire

// ===== src/idr_sync.sv
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module idr_sync #(
    parameter int W = 2
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_q <= '1;
            dout   <= '1;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== src/idr_target.sv
// Target end: answers the reserved identification read
`timescale 1ns/1ps
`default_nettype none
`include "idr_map.svh"
module idr_target #(
    parameter logic [11:0] MAKER_ID = 12'h123, // arbitrary value
    parameter logic [3:0]  DENSITY  = 4'h1,    // arbitrary value
    parameter logic [7:0]  PROD_LOW = 8'h22    // arbitrary value
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Link
    idr_link_if.tgt   link,
    // Straps
    input  wire logic addr_select_pin_hi,
    input  wire logic addr_select_pin_mid,
    input  wire logic addr_select_pin_lo,
    // Status
    output logic      idActive
);
    import idr_pkg::*;
    logic [4:0] pinS;
    logic       sclQ, sdaQ, sclP_q, sdaP_q;
    logic [2:0] strap_q;
    idr_tstate_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] idx_q, idx_d;
    logic       oe_q, oe_d;
    logic       okDev_q, okDev_d;
    logic [23:0] idWord;
    logic [7:0] idByte;
    logic       rise, fall, startC, stopC;

    idr_sync #(.W(5)) uSync (
        .clock (clock),
        .nrst  (nrst),
        .din   ({link.scl, link.sda, addr_select_pin_hi, addr_select_pin_mid,
                 addr_select_pin_lo}),
        .dout  (pinS)
    );
    assign sclQ = pinS[4];
    assign sdaQ = pinS[3];
    assign rise   = sclQ & ~sclP_q;
    assign fall   = ~sclQ & sclP_q;
    assign startC = sclQ & sclP_q & sdaP_q & ~sdaQ;
    assign stopC  = sclQ & sclP_q & ~sdaP_q & sdaQ;
    // Constant only; no path writes it
    assign idWord = {MAKER_ID, DENSITY, PROD_LOW};
    always_comb begin
        case (idx_q)
            2'h0:    idByte = idWord[23:16];
            2'h1:    idByte = idWord[15:8];
            default: idByte = idWord[7:0];
        endcase
    end

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        oe_d = oe_q;
        okDev_d = okDev_q;
        if (stopC) begin
            st_d = IDR_T_IDLE;
            oe_d = 1'b0;
        end else if (startC) begin
            // Repeated start only continues after a matched device word
            st_d = (st_q == IDR_T_WAITRS) ? IDR_T_RD : IDR_T_RSV;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                IDR_T_IDLE: oe_d = 1'b0;
                IDR_T_RSV, IDR_T_DEV, IDR_T_RD: begin
                    if (rise && cnt_q < 4'h8) begin
                        sh_d  = {sh_q[6:0], sdaQ};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == 4'h8) begin
                        oe_d = 1'b0;
                        if (st_q == IDR_T_RSV && sh_q == `IDR_RSV_WR) begin
                            oe_d = 1'b1;
                        end else if (st_q == IDR_T_DEV && sh_q[7:4] == `IDR_TYPE_CODE
                                && sh_q[3:1] == strap_q) begin
                            oe_d = 1'b1;
                        end else if (st_q == IDR_T_RD && sh_q == `IDR_RSV_RD) begin
                            oe_d = 1'b1;
                        end else begin
                            st_d = IDR_T_IDLE;
                        end
                        cnt_d = 4'h9;
                    end else if (fall && cnt_q == 4'h9) begin
                        oe_d  = 1'b0;
                        cnt_d = 4'h0;
                        case (st_q)
                            IDR_T_RSV: st_d = IDR_T_DEV;
                            IDR_T_DEV: st_d = IDR_T_WAITRS;
                            default: begin
                                st_d  = IDR_T_SEND;
                                idx_d = 2'h0;
                                oe_d  = ~idWord[23];
                                cnt_d = 4'h1;
                            end
                        endcase
                    end
                end
                IDR_T_WAITRS: oe_d = 1'b0;
                IDR_T_SEND: begin
                    if (fall) begin
                        if (cnt_q == 4'h8) begin
                            oe_d = 1'b0;
                            st_d = IDR_T_MACK;
                        end else begin
                            oe_d  = ~idByte[3'(7 - cnt_q)];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                IDR_T_MACK: begin
                    if (rise) begin
                        okDev_d = ~sdaQ;
                    end else if (fall) begin
                        if (okDev_q) begin
                            // Wrap after third byte
                            idx_d = (idx_q == `IDR_ID_BYTES - 2'h1) ? 2'h0 : idx_q + 2'h1;
                            st_d  = IDR_T_SEND;
                            cnt_d = 4'h1;
                            oe_d  = ~idWord[23 - 8 * int'(idx_d)];
                        end else begin
                            st_d = IDR_T_IDLE;
                        end
                    end
                end
                default: st_d = IDR_T_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q <= IDR_T_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            idx_q <= 2'h0;
            oe_q <= 1'b0;
            okDev_q <= 1'b0;
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
            strap_q <= 3'h0;
            idActive <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            oe_q <= oe_d;
            okDev_q <= okDev_d;
            sclP_q <= sclQ;
            sdaP_q <= sdaQ;
            strap_q <= pinS[2:0];
            idActive <= (st_d == IDR_T_SEND) || (st_d == IDR_T_MACK);
        end
    end
    assign link.sdaOeTgt = oe_q;
endmodule
`default_nettype wire

// ===== src/idr_controller.sv
// Controller end: recovery then identification read
`timescale 1ns/1ps
`default_nettype none
`include "idr_map.svh"
module idr_controller #(
    parameter logic [15:0] HALF = `IDR_SCL_HALF
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Link
    idr_link_if.ctl          link,
    // Request
    input  wire logic        go,
    input  wire logic [2:0]  devCode,
    // Answer
    output logic             busy,
    output logic             done,
    output logic             fail,
    output logic [23:0]      idValue
);
    import idr_pkg::*;
    logic [1:0] pinS;
    idr_cstate_t st_q, st_d;
    logic [15:0] tm_q, tm_d;
    logic        ph_q, ph_d;
    logic [3:0]  bit_q, bit_d;
    logic [1:0]  step_q, step_d;
    logic [7:0]  tx_q, tx_d;
    logic [23:0] rx_q, rx_d;
    logic [1:0]  nb_q, nb_d;
    logic        scl_q, scl_d, sda_q, sda_d, done_d, fail_d, tick;

    idr_sync #(.W(2)) uSync (
        .clock (clock),
        .nrst  (nrst),
        .din   ({link.scl, link.sda}),
        .dout  (pinS)
    );
    assign tick = (tm_q == 16'h0000);

    always_comb begin
        st_d = st_q; tm_d = tick ? HALF : tm_q - 16'h0001;
        ph_d = ph_q; bit_d = bit_q; step_d = step_q; tx_d = tx_q;
        rx_d = rx_q; nb_d = nb_q; scl_d = scl_q; sda_d = sda_q;
        done_d = 1'b0; fail_d = 1'b0;
        // sda_q high means pull low; released otherwise
        case (st_q)
            IDR_C_IDLE: if (go) begin st_d = IDR_C_RECOV; bit_d = 4'h0; ph_d = 1'b0; end
            IDR_C_RECOV: if (tick) begin
                sda_d = 1'b0;
                ph_d  = ~ph_q;
                scl_d = ~ph_q;
                if (ph_q) bit_d = bit_q + 4'h1;
                if (ph_q && bit_q == `IDR_RECOV_CLKS) begin
                    st_d = IDR_C_START; step_d = 2'h0; scl_d = 1'b0;
                end
            end
            IDR_C_START: if (tick) begin
                ph_d = ~ph_q;
                if (!ph_q) begin scl_d = 1'b0; sda_d = 1'b0; end
                else begin
                    sda_d = 1'b1;
                    tx_d  = `IDR_RSV_WR;
                    st_d  = IDR_C_TXBIT; bit_d = 4'h0; ph_d = 1'b0;
                end
            end
            // Clock low, release data, clock high, then pull data low
            IDR_C_RSTART: if (tick) begin
                bit_d = bit_q + 4'h1;
                if (bit_q == 4'h0) begin scl_d = 1'b1; sda_d = 1'b0; end
                else if (bit_q == 4'h1) scl_d = 1'b0;
                else begin
                    sda_d = 1'b1;
                    tx_d  = `IDR_RSV_RD;
                    st_d  = IDR_C_TXBIT; bit_d = 4'h0; ph_d = 1'b0;
                end
            end
            // Data only moves while the clock is low, else it reads as start or stop
            IDR_C_TXBIT: if (tick) begin
                ph_d = ~ph_q;
                if (!ph_q) begin scl_d = 1'b1; sda_d = ~tx_q[7]; end
                else begin
                    scl_d = 1'b0;
                    tx_d = {tx_q[6:0], 1'b0};
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h7) st_d = IDR_C_TXACK;
                end
            end
            IDR_C_TXACK: if (tick) begin
                ph_d = ~ph_q;
                if (!ph_q) begin scl_d = 1'b1; sda_d = 1'b0; end
                else begin
                    scl_d = 1'b0; bit_d = 4'h0;
                    if (pinS[0]) begin st_d = IDR_C_STOP; fail_d = 1'b1; end
                    else if (step_q == 2'h0) begin
                        step_d = 2'h1; st_d = IDR_C_TXBIT;
                        tx_d = {`IDR_TYPE_CODE, devCode, 1'b0};
                    end else if (step_q == 2'h1) begin
                        step_d = 2'h2; st_d = IDR_C_RSTART;
                    end else begin
                        st_d = IDR_C_RXBIT; nb_d = 2'h0;
                    end
                end
            end
            IDR_C_RXBIT: if (tick) begin
                ph_d = ~ph_q;
                if (!ph_q) begin scl_d = 1'b1; sda_d = 1'b0; end
                else begin
                    scl_d = 1'b0;
                    rx_d = {rx_q[22:0], pinS[0]};
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h7) st_d = IDR_C_RXACK;
                end
            end
            IDR_C_RXACK: if (tick) begin
                ph_d = ~ph_q;
                if (!ph_q) begin
                    scl_d = 1'b1;
                    sda_d = (nb_q != `IDR_ID_BYTES - 2'h1);
                end else begin
                    scl_d = 1'b0; bit_d = 4'h0;
                    if (nb_q == `IDR_ID_BYTES - 2'h1) begin
                        st_d = IDR_C_STOP; done_d = 1'b1;
                    end else begin
                        nb_d = nb_q + 2'h1; st_d = IDR_C_RXBIT;
                    end
                end
            end
            // Clock low with data low, clock high, then release data
            IDR_C_STOP: if (tick) begin
                bit_d = bit_q + 4'h1;
                if (bit_q == 4'h0) begin scl_d = 1'b1; sda_d = 1'b1; end
                else if (bit_q == 4'h1) scl_d = 1'b0;
                else begin sda_d = 1'b0; st_d = IDR_C_DONE; ph_d = 1'b0; end
            end
            IDR_C_DONE: if (tick) begin
                ph_d = ~ph_q;
                if (!ph_q) scl_d = 1'b0;
                else begin sda_d = 1'b0; st_d = IDR_C_IDLE; end
            end
            default: st_d = IDR_C_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q <= IDR_C_IDLE; tm_q <= 16'h0000; ph_q <= 1'b0;
            bit_q <= 4'h0; step_q <= 2'h0; tx_q <= 8'h00; rx_q <= 24'h000000;
            nb_q <= 2'h0; scl_q <= 1'b0; sda_q <= 1'b0;
            busy <= 1'b0; done <= 1'b0; fail <= 1'b0; idValue <= 24'h000000;
        end else begin
            st_q <= st_d; tm_q <= tm_d; ph_q <= ph_d;
            bit_q <= bit_d; step_q <= step_d; tx_q <= tx_d; rx_q <= rx_d;
            nb_q <= nb_d; scl_q <= scl_d; sda_q <= sda_d;
            busy <= (st_d != IDR_C_IDLE);
            done <= done_d;
            fail <= fail_d;
            if (done_d) idValue <= rx_d;
        end
    end
    assign link.sclOe    = scl_q;
    assign link.sdaOeCtl = sda_q;
endmodule
`default_nettype wire

// ===== testbench/idr_chk.sv
// Checker watching the shared two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
`include "idr_map.svh"
module idr_chk #(
    parameter logic [23:0] ID_VALUE = 24'h000000
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Link enables and wires
    input  wire logic sdaOeCtl,
    input  wire logic sdaOeTgt,
    input  wire logic scl,
    input  wire logic sda,
    // Straps
    input  wire logic addr_select_pin_hi,
    input  wire logic addr_select_pin_mid,
    input  wire logic addr_select_pin_lo
);
    // Stop must follow the final not-acknowledge within a few half periods
    localparam int STOP_MAX = 120;
    logic       sclQ;
    logic       sdaQ;
    logic       inFrame;
    logic       okDev;
    logic [3:0] bitCnt;
    logic [2:0] byteNo;
    logic [7:0] shReg;
    logic [7:0] firstB;
    wire        startEv = sclQ & scl & sdaQ & ~sda;
    wire        stopEv  = sclQ & scl & ~sdaQ & sda;
    wire        rise    = ~sclQ & scl & inFrame;
    wire        ackSlot = rise & (bitCnt == 4'h8);
    wire        devOk   = (shReg[7:4] == `IDR_TYPE_CODE)
                        & (shReg[3:1] == {addr_select_pin_hi, addr_select_pin_mid,
                                          addr_select_pin_lo});
    wire        rdData  = rise & (bitCnt < 4'h8) & (firstB == `IDR_RSV_RD) & okDev
                        & (byteNo != 3'h0) & (byteNo < 3'h4);
    wire [4:0]  bitIdx  = 5'(8 * (3 - int'(byteNo)) + 7 - int'(bitCnt));
    wire        lastAck = ackSlot & (byteNo == 3'h3) & (firstB == `IDR_RSV_RD) & okDev;

    // Recovery pulses outside a frame are not decoded as bits
    always_ff @(posedge clock) begin
        sclQ <= scl;
        sdaQ <= sda;
        if (!nrst) begin
            inFrame <= 1'b0;
            okDev   <= 1'b0;
            bitCnt  <= 4'h0;
            byteNo  <= 3'h0;
            shReg   <= 8'h00;
            firstB  <= 8'h00;
        end else if (startEv) begin
            inFrame <= 1'b1;
            bitCnt  <= 4'h0;
            byteNo  <= 3'h0;
            firstB  <= 8'h00;
        end else if (stopEv) begin
            inFrame <= 1'b0;
            okDev   <= 1'b0;
        end else if (ackSlot) begin
            bitCnt <= 4'h0;
            byteNo <= byteNo + 3'h1;
            if (byteNo == 3'h0) begin
                firstB <= shReg;
            end
            if (byteNo == 3'h1 && firstB == `IDR_RSV_WR && !sda) begin
                okDev <= 1'b1;
            end
        end else if (rise) begin
            bitCnt <= bitCnt + 4'h1;
            shReg  <= {shReg[6:0], sda};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_rsv_wr_ack: assert property (ackSlot && byteNo == 3'h0 && shReg == `IDR_RSV_WR |-> !sda)
        else $error("reserved write byte not acknowledged");
    chk_rsv_rd_ack: assert property (ackSlot && byteNo == 3'h0 && shReg == `IDR_RSV_RD && okDev |-> !sda)
        else $error("reserved read byte not acknowledged");
    chk_dev_word_ack: assert property (ackSlot && byteNo == 3'h1 && firstB == `IDR_RSV_WR && devOk |-> !sda)
        else $error("matching device word not acknowledged");
    chk_dev_word_nack: assert property (ackSlot && byteNo == 3'h1 && firstB == `IDR_RSV_WR && !devOk |-> sda)
        else $error("foreign device word acknowledged");
    chk_id_bit_value: assert property (rdData |-> sda == ID_VALUE[bitIdx])
        else $error("identification bit wrong");
    chk_ctl_read_release: assert property (rdData |-> !sdaOeCtl)
        else $error("controller pulls data line during read bit");
    chk_third_byte_nack: assert property (lastAck |-> sda)
        else $error("third byte acknowledged by controller");
    chk_stop_after_nack: assert property (lastAck |-> ##[1:STOP_MAX] stopEv)
        else $error("no stop after final byte");
    chk_tgt_quiet_high: assert property (scl && $past(scl) |-> $stable(sdaOeTgt))
        else $error("target moved data line while clock high");

    cover property (ackSlot && byteNo == 3'h0 && shReg == `IDR_RSV_RD && okDev);
    cover property (ackSlot && byteNo == 3'h1 && firstB == `IDR_RSV_WR && !devOk);
    cover property (lastAck ##[1:STOP_MAX] stopEv);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Bench joining both ends, results compared with a queue model
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [11:0] MAKER = 12'h3C7; // arbitrary value
    localparam logic [3:0]  DENS  = 4'h9;    // arbitrary value
    localparam logic [7:0]  PLOW  = 8'h6B;   // arbitrary value
    localparam logic [23:0] ID    = {MAKER, DENS, PLOW};
    logic        clock;
    logic        nrst;
    logic        go;
    logic [2:0]  devCode;
    logic [2:0]  straps;
    logic        busy;
    logic        done;
    logic        fail;
    logic        idActive;
    logic [23:0] idValue;
    logic [23:0] lastId;
    int          err_count;
    int          n_tests;
    int          expQ[$];

    idr_link_if idr_link_if_i ();
    idr_target #(.MAKER_ID(MAKER), .DENSITY(DENS), .PROD_LOW(PLOW)) idr_target_i (
        .clock(clock), .nrst(nrst), .link(idr_link_if_i),
        .addr_select_pin_hi(straps[2]), .addr_select_pin_mid(straps[1]),
        .addr_select_pin_lo(straps[0]), .idActive(idActive));
    // Short half period keeps the run brief, still above the target's sync delay
    idr_controller #(.HALF(16'h0008)) idr_controller_i (
        .clock(clock), .nrst(nrst), .link(idr_link_if_i), .go(go), .devCode(devCode),
        .busy(busy), .done(done), .fail(fail), .idValue(idValue));
    idr_chk #(.ID_VALUE(ID)) idr_chk_i (
        .clock(clock), .nrst(nrst), .sdaOeCtl(idr_link_if_i.sdaOeCtl),
        .sdaOeTgt(idr_link_if_i.sdaOeTgt), .scl(idr_link_if_i.scl), .sda(idr_link_if_i.sda),
        .addr_select_pin_hi(straps[2]), .addr_select_pin_mid(straps[1]),
        .addr_select_pin_lo(straps[0]));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One identification read; a second go is pulsed mid-run and must be ignored
    task automatic run(input logic [2:0] dc, input logic [2:0] st);
        int   e;
        logic saw;
        bit   got;
        saw = 1'b0;
        got = 1'b0;
        @(posedge clock);
        devCode <= dc;
        straps  <= st;
        go      <= 1'b1;
        expQ.push_back((dc == st) ? int'(ID) : -1);
        for (int n = 0; n < 4000 && !got; n++) begin
            @(posedge clock);
            go <= (n == 40);
            @(negedge clock);
            saw |= (idActive === 1'b1);
            got = (done === 1'b1) || (fail === 1'b1);
        end
        e = expQ.pop_front();
        check("done", {23'h0, e >= 0}, {23'h0, done});
        check("fail", {23'h0, e < 0}, {23'h0, fail});
        check("idValue", (e < 0) ? lastId : 24'(e), idValue);
        check("idActive seen", {23'h0, e >= 0}, {23'h0, saw});
        if (e >= 0) begin
            lastId = 24'(e);
        end
        for (int n = 0; n < 2000 && busy !== 1'b0; n++) begin
            @(negedge clock);
        end
        repeat (3) @(negedge clock);
        check("busy", 24'h0, {23'h0, busy});
    endtask

    initial begin
        logic [2:0] st;
        nrst      = 1'b0;
        go        = 1'b0;
        devCode   = 3'h0;
        straps    = 3'h0;
        lastId    = 24'h0;
        err_count = 0;
        n_tests   = 0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        check("idValue reset", 24'h0, idValue);
        void'($urandom(78577));
        // Every strap code once, reads back to back
        for (int i = 0; i < 8; i++) begin
            run(3'(i), 3'(i));
        end
        // Wrong device codes must be turned away
        for (int i = 0; i < 4; i++) begin
            st = 3'($urandom_range(7));
            run(st ^ 3'($urandom_range(6) + 1), st);
        end
        run(st, st);
        wrap_up();
    end

    // Thirteen reads of at most about thirteen hundred cycles each
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
`default_nettype wire
